// >>> buckg_defs.svh
// constants of the buck gate sequencer: offsets, fields, reset values
`ifndef BUCKG_DEFS_SVH
`define BUCKG_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define BUCKG_ADDR_W        5
`define BUCKG_OFS_CTRL      5'h00
`define BUCKG_OFS_STATUS    5'h04
`define BUCKG_OFS_IRQ_STAT  5'h08
`define BUCKG_OFS_IRQ_MASK  5'h0c
`define BUCKG_OFS_PULSES    5'h10

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define BUCKG_CTRL_RUN      0
`define BUCKG_CTRL_RST      1'h1
`define BUCKG_IRQ_W         4
`define BUCKG_IRQ_FAULT     0
`define BUCKG_IRQ_TRANS     1
`define BUCKG_IRQ_START     2
`define BUCKG_IRQ_SKIP      3
`define BUCKG_MASK_RST      4'h0
`define BUCKG_PULSE_W       16

// ----------------------------------------------------------------------
// synchroniser bit positions
// ----------------------------------------------------------------------
`define BUCKG_SYNC_W        10
`define BUCKG_SI_OSC        0
`define BUCKG_SI_FB_REG     1
`define BUCKG_SI_FB_FAULT   2
`define BUCKG_SI_HOLDOFF    3
`define BUCKG_SI_STARTUP    4
`define BUCKG_SI_FAULT_EN   5
`define BUCKG_SI_MAX        6
`define BUCKG_SI_DETECT     7
`define BUCKG_SI_INHIBIT    8
`define BUCKG_SI_SUPPLY     9

`endif

// >>> buckg_pkg.sv
// types of the buck gate sequencer
package buckg_pkg;

  // ----------------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    BUCKG_HOLDOFF  = 5'h01,
    BUCKG_STARTUP  = 5'h02,
    BUCKG_NORMAL   = 5'h04,
    BUCKG_FAST_DIS = 5'h08,
    BUCKG_SLOW_DIS = 5'h10
  } buckg_state_type;

endpackage

// >>> buckg_sync.sv
// two-flop synchroniser for the comparator and oscillator inputs
`timescale 1ns/1ps
`include "buckg_defs.svh"

module buckg_sync (
  // clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_srst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [`BUCKG_SYNC_W-1:0]  i_async,
  output logic      [`BUCKG_SYNC_W-1:0]  o_sync
);

  logic [`BUCKG_SYNC_W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// >>> buckg_irq.sv
// sticky event status, mask and level interrupt
`timescale 1ns/1ps
`include "buckg_defs.svh"

module buckg_irq (
  // clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_srst,
  // events and software access
  input  wire logic [`BUCKG_IRQ_W-1:0]  i_event,
  input  wire logic                     i_stat_wr,
  input  wire logic                     i_mask_wr,
  input  wire logic [`BUCKG_IRQ_W-1:0]  i_wdata,
  // state
  output logic      [`BUCKG_IRQ_W-1:0]  o_status,
  output logic      [`BUCKG_IRQ_W-1:0]  o_mask,
  output logic                          o_irq
);

  wire [`BUCKG_IRQ_W-1:0] clr_w    = i_stat_wr ? i_wdata : '0;
  // a new event beats a write-one-to-clear in the same cycle
  wire [`BUCKG_IRQ_W-1:0] status_d = (o_status & ~clr_w) | i_event;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_status <= '0;
      o_mask   <= `BUCKG_MASK_RST;
      o_irq    <= 1'b0;
    end else begin
      o_status <= status_d;
      if (i_mask_wr) begin
        o_mask <= i_wdata;
      end
      o_irq <= |(status_d & (i_mask_wr ? i_wdata : o_mask));
    end
  end

endmodule

// >>> buckg_top.sv
// buck gate sequencer: gate latch, soft start, hiccup fault timing, registers
`timescale 1ns/1ps
`include "buckg_defs.svh"

module buckg_top (
  // clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_srst,
  // oscillator and comparator levels, asynchronous
  input  wire logic                      i_osc_charge,
  input  wire logic                      i_fb_below_reg,
  input  wire logic                      i_fb_below_fault,
  input  wire logic                      i_cs_above_holdoff,
  input  wire logic                      i_cs_above_startup,
  input  wire logic                      i_cs_above_fault_en,
  input  wire logic                      i_cs_above_max,
  input  wire logic                      i_cs_below_detect,
  input  wire logic                      i_cs_below_inhibit,
  input  wire logic                      i_supply_ok,
  // power stage and timing capacitor control
  output logic                           o_gate_n,
  output logic                           o_ref_fixed,
  output logic                           o_cs_charge,
  output logic                           o_cs_fast_dis,
  output logic                           o_cs_slow_dis,
  // avalon-mm slave
  input  wire logic [`BUCKG_ADDR_W-1:0]  i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output logic      [31:0]               o_avs_readdata,
  output logic                           o_avs_waitrequest,
  // interrupt
  output logic                           o_irq
);

  // ----------------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------------
  logic [`BUCKG_SYNC_W-1:0] sync_s;

  buckg_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_async    ({i_supply_ok, i_cs_below_inhibit, i_cs_below_detect,
                  i_cs_above_max, i_cs_above_fault_en, i_cs_above_startup,
                  i_cs_above_holdoff, i_fb_below_fault, i_fb_below_reg,
                  i_osc_charge}),
    .o_sync     (sync_s)
  );

  wire osc_charge_s  = sync_s[`BUCKG_SI_OSC];
  wire fb_reg_s      = sync_s[`BUCKG_SI_FB_REG];
  wire fb_fault_s    = sync_s[`BUCKG_SI_FB_FAULT];
  wire cs_holdoff_s  = sync_s[`BUCKG_SI_HOLDOFF];
  wire cs_startup_s  = sync_s[`BUCKG_SI_STARTUP];
  wire cs_fault_en_s = sync_s[`BUCKG_SI_FAULT_EN];
  wire cs_max_s      = sync_s[`BUCKG_SI_MAX];
  wire cs_detect_s   = sync_s[`BUCKG_SI_DETECT];
  wire cs_inhibit_s  = sync_s[`BUCKG_SI_INHIBIT];
  wire supply_s      = sync_s[`BUCKG_SI_SUPPLY];

  // ----------------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------------
  buckg_pkg::buckg_state_type   state_q;
  buckg_pkg::buckg_state_type   state_d;
  logic                         run_q;
  logic                         fault_en_q;
  logic                         osc_prev_q;
  logic [`BUCKG_PULSE_W-1:0]    pulse_cnt_q;
  logic [`BUCKG_IRQ_W-1:0]      irq_status;
  logic [`BUCKG_IRQ_W-1:0]      irq_mask;

  // switching is allowed only outside holdoff and slow discharge
  function automatic logic gate_allowed(input buckg_pkg::buckg_state_type s);
    gate_allowed = (s == buckg_pkg::BUCKG_STARTUP) ||
                   (s == buckg_pkg::BUCKG_NORMAL)  ||
                   (s == buckg_pkg::BUCKG_FAST_DIS);
  endfunction

  wire live_w = run_q & supply_s;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      buckg_pkg::BUCKG_HOLDOFF: begin
        if (cs_holdoff_s) begin
          state_d = buckg_pkg::BUCKG_STARTUP;
        end
      end
      buckg_pkg::BUCKG_STARTUP: begin
        if (cs_fault_en_s) begin
          state_d = buckg_pkg::BUCKG_NORMAL;
        end
      end
      buckg_pkg::BUCKG_NORMAL: begin
        if (fb_fault_s) begin
          state_d = buckg_pkg::BUCKG_FAST_DIS;
        end
      end
      buckg_pkg::BUCKG_FAST_DIS: begin
        if (cs_detect_s && fb_fault_s) begin
          state_d = buckg_pkg::BUCKG_SLOW_DIS;
        end else if (cs_detect_s) begin
          state_d = buckg_pkg::BUCKG_NORMAL;
        end
      end
      buckg_pkg::BUCKG_SLOW_DIS: begin
        if (cs_inhibit_s) begin
          state_d = buckg_pkg::BUCKG_STARTUP;
        end
      end
      default: begin
        state_d = buckg_pkg::BUCKG_HOLDOFF;
      end
    endcase
    if (!live_w) begin
      state_d = buckg_pkg::BUCKG_HOLDOFF;
    end
  end

  // ----------------------------------------------------------------------
  // gate latch and analog controls
  // ----------------------------------------------------------------------
  wire allow_d   = gate_allowed(state_d);
  wire allow_q   = gate_allowed(state_q);
  // latch held once set; cleared by discharge phase or a blocking state
  wire gate_on_d = osc_charge_s & allow_d & (~o_gate_n | fb_reg_s);
  wire gate_n_d  = ~gate_on_d;
  wire st_norm_d = (state_d == buckg_pkg::BUCKG_NORMAL);
  wire st_fast_d = (state_d == buckg_pkg::BUCKG_FAST_DIS);
  wire st_slow_d = (state_d == buckg_pkg::BUCKG_SLOW_DIS);
  wire charge_d  = (state_d == buckg_pkg::BUCKG_HOLDOFF) ||
                   (state_d == buckg_pkg::BUCKG_STARTUP) ||
                   (st_norm_d && !cs_max_s);
  // reference comparator output is a level, so outside holdoff the clamp simply follows it
  wire ref_fix_d = cs_startup_s & (state_d != buckg_pkg::BUCKG_HOLDOFF);
  wire fault_en_d = st_norm_d | st_fast_d;

  // ----------------------------------------------------------------------
  // events
  // ----------------------------------------------------------------------
  wire ev_fault = (state_q == buckg_pkg::BUCKG_FAST_DIS) && st_slow_d;
  wire ev_trans = (state_q == buckg_pkg::BUCKG_FAST_DIS) && st_norm_d && live_w;
  wire ev_start = (state_q == buckg_pkg::BUCKG_STARTUP) && st_norm_d;
  // charge phase just ended without the latch ever setting
  wire ev_skip  = osc_prev_q & ~osc_charge_s & allow_q & o_gate_n;
  wire [`BUCKG_IRQ_W-1:0] events_w = {ev_skip, ev_start, ev_trans, ev_fault};

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q       <= buckg_pkg::BUCKG_HOLDOFF;
      o_gate_n      <= 1'b1;
      o_ref_fixed   <= 1'b0;
      o_cs_charge   <= 1'b0;
      o_cs_fast_dis <= 1'b0;
      o_cs_slow_dis <= 1'b0;
      fault_en_q    <= 1'b0;
      osc_prev_q    <= 1'b0;
    end else begin
      state_q       <= state_d;
      o_gate_n      <= gate_n_d;
      o_ref_fixed   <= ref_fix_d;
      o_cs_charge   <= charge_d;
      o_cs_fast_dis <= st_fast_d;
      o_cs_slow_dis <= st_slow_d;
      fault_en_q    <= fault_en_d;
      osc_prev_q    <= osc_charge_s;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pulse_cnt_q <= '0;
    end else if (o_gate_n && !gate_n_d) begin
      pulse_cnt_q <= pulse_cnt_q + `BUCKG_PULSE_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // avalon-mm slave, one wait state per access
  // ----------------------------------------------------------------------
  wire req_w    = i_avs_read | i_avs_write;
  wire accept_w = req_w & ~o_avs_waitrequest;
  wire wr_w     = accept_w & i_avs_write & i_avs_byteenable[0];
  wire hit_ctrl = (i_avs_address == `BUCKG_OFS_CTRL);
  wire hit_stat = (i_avs_address == `BUCKG_OFS_STATUS);
  wire hit_ist  = (i_avs_address == `BUCKG_OFS_IRQ_STAT);
  wire hit_imsk = (i_avs_address == `BUCKG_OFS_IRQ_MASK);
  wire hit_puls = (i_avs_address == `BUCKG_OFS_PULSES);
  wire [31:0] status_w = {22'h0, o_cs_slow_dis, fault_en_q, o_ref_fixed,
                          ~o_gate_n, 1'b0, state_q};
  wire [31:0] rdata_w  = hit_ctrl ? {31'h0, run_q} :
                         hit_stat ? status_w :
                         hit_ist  ? {28'h0, irq_status} :
                         hit_imsk ? {28'h0, irq_mask} :
                         hit_puls ? {16'h0, pulse_cnt_q} :
                         32'h0;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0;
      run_q             <= `BUCKG_CTRL_RST;
    end else begin
      o_avs_waitrequest <= ~(req_w & o_avs_waitrequest);
      if (req_w && o_avs_waitrequest) begin
        o_avs_readdata <= rdata_w;
      end
      if (wr_w && hit_ctrl) begin
        run_q <= i_avs_writedata[`BUCKG_CTRL_RUN];
      end
    end
  end

  buckg_irq u_irq (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_event    (events_w),
    .i_stat_wr  (wr_w & hit_ist),
    .i_mask_wr  (wr_w & hit_imsk),
    .i_wdata    (i_avs_writedata[`BUCKG_IRQ_W-1:0]),
    .o_status   (irq_status),
    .o_mask     (irq_mask),
    .o_irq      (o_irq)
  );

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  sequence fault_seen_s;
    (state_q == buckg_pkg::BUCKG_NORMAL) && fb_fault_s && live_w;
  endsequence
  sequence valid_fault_s;
    (state_q == buckg_pkg::BUCKG_FAST_DIS) && cs_detect_s && fb_fault_s && live_w;
  endsequence
  sequence slow_hold_s;
    o_cs_slow_dis && o_gate_n && !o_cs_charge;
  endsequence

  gate_set_on_a: assert property (
    osc_charge_s && allow_d && fb_reg_s |=> !o_gate_n)
    else $error("gate not set on low feedback in charge phase");
  gate_hold_on_a: assert property (
    osc_charge_s && allow_d && !o_gate_n |=> !o_gate_n)
    else $error("gate dropped during charge phase");
  gate_discharge_off_a: assert property (
    !osc_charge_s |=> o_gate_n)
    else $error("gate on during discharge phase");
  pulse_skip_a: assert property (
    osc_charge_s && !fb_reg_s && o_gate_n |=> o_gate_n)
    else $error("gate set with feedback above threshold");
  holdoff_gate_a: assert property (
    state_q == buckg_pkg::BUCKG_HOLDOFF |-> o_gate_n && !o_ref_fixed)
    else $error("gate or fixed reference active in holdoff");
  ref_clamp_a: assert property (
    !cs_startup_s |=> !o_ref_fixed)
    else $error("fixed reference before 2.3 V");
  ref_fixed_a: assert property (
    cs_startup_s && live_w && state_q != buckg_pkg::BUCKG_HOLDOFF |=> o_ref_fixed)
    else $error("reference not fixed above 2.3 V");
  startup_nofault_a: assert property (
    (state_q == buckg_pkg::BUCKG_STARTUP) && !cs_fault_en_s |=> !fault_en_q)
    else $error("fault detection enabled below 2.5 V");
  normal_hold_a: assert property (
    (state_q == buckg_pkg::BUCKG_NORMAL) && live_w && !fb_fault_s && !cs_max_s
    |=> o_cs_charge && !o_cs_fast_dis)
    else $error("timing capacitor not held at upper level");
  fast_dis_a: assert property (
    fault_seen_s |=> o_cs_fast_dis && !o_cs_charge && fault_en_q)
    else $error("no fast discharge on fault");
  valid_fault_a: assert property (
    valid_fault_s |=> slow_hold_s ##1 (o_gate_n || !o_cs_slow_dis))
    else $error("valid fault did not latch slow discharge");
  slow_restart_a: assert property (
    (state_q == buckg_pkg::BUCKG_SLOW_DIS) && cs_inhibit_s && live_w
    |=> (state_q == buckg_pkg::BUCKG_STARTUP) && o_cs_charge && !o_cs_slow_dis)
    else $error("no restart at 1.5 V");
  hiccup_a: assert property (
    (state_q == buckg_pkg::BUCKG_STARTUP) && cs_fault_en_s && fb_fault_s && live_w
    |=> fault_en_q ##1 (o_cs_fast_dis || !live_w))
    else $error("persistent fault did not repeat discharge");
  transient_a: assert property (
    (state_q == buckg_pkg::BUCKG_FAST_DIS) && cs_detect_s && !fb_fault_s && live_w
    |=> (state_q == buckg_pkg::BUCKG_NORMAL) && !o_cs_slow_dis && !o_cs_fast_dis)
    else $error("transient not treated as recovery");
  supply_loss_a: assert property (
    !live_w |=> (state_q == buckg_pkg::BUCKG_HOLDOFF) && o_gate_n &&
                !o_cs_slow_dis && !fault_en_q)
    else $error("supply loss did not return to holdoff");

endmodule

// >>> buckg_plant.sv
// behavioural timing capacitor, oscillator and output stage around the sequencer
`timescale 1ns/1ps

module buckg_plant (
  // clock
  input  wire logic       i_core_clk,
  // sequencer outputs and bench overrides
  input  wire logic       i_gate_n,
  input  wire logic       i_ref_fixed,
  input  wire logic       i_charge,
  input  wire logic       i_fast,
  input  wire logic       i_slow,
  input  wire logic       i_short,
  input  wire logic       i_light,
  // oscillator phase and comparator levels
  output logic            o_osc,
  output logic      [7:0] o_cmp
);
  int cap_mv = 0;
  int fb_mv = 0;
  int osc_n = 0;
  wire logic lo_reg = fb_mv < (i_ref_fixed ? 1250 : cap_mv / 2);

  // a short pulls both feedback comparators whatever the divider shows
  assign o_cmp = {cap_mv <= 1500, cap_mv <= 2400, cap_mv >= 2600, cap_mv >= 2500,
                  cap_mv > 2300, cap_mv > 700, i_short | fb_mv < 1150,
                  i_short | (lo_reg & !i_light)};
  // 20 of 25 cycles charging: oscillator runs free
  assign o_osc = osc_n < 20;

  always @(posedge i_core_clk) begin
    osc_n <= (osc_n == 24) ? 0 : osc_n + 1;
    cap_mv <= cap_mv + (i_charge ? 4 : 0) - (i_fast ? 2 : 0) - (i_slow ? 1 : 0);
    // output held while the bench overrides the comparators
    if (!i_short && !i_light)
      fb_mv <= i_gate_n ? ((fb_mv > 0) ? fb_mv - 1 : 0) : fb_mv + 8;
  end
endmodule

// >>> tb_buckg_top.sv
// self-checking bench of the buck gate sequencer
`timescale 1ns/1ps
`include "buckg_defs.svh"

module tb_buckg_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        sup = 1'b1;
  logic        short = 1'b0;
  logic        light = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hf;
  logic        gate_n, ref_fixed, chg, fst, slw, irq, wreq, osc;
  logic [31:0] rdata, ev, em, p1, p2;
  logic [7:0]  cmp;
  logic [31:0] exp_v[$];
  logic [31:0] exp_m[$];
  int          n_errors = 0;
  int          compares = 0;
  int          lo_n = 0;
  int          bad_dis = 0;
  int          bad_slow = 0;
  int          bad_hold = 0;
  int          n, k;

  buckg_top buckg_top_inst (
    .i_core_clk(clk), .i_srst(srst), .i_osc_charge(osc),
    .i_fb_below_reg(cmp[0]), .i_fb_below_fault(cmp[1]), .i_cs_above_holdoff(cmp[2]),
    .i_cs_above_startup(cmp[3]), .i_cs_above_fault_en(cmp[4]), .i_cs_above_max(cmp[5]),
    .i_cs_below_detect(cmp[6]), .i_cs_below_inhibit(cmp[7]), .i_supply_ok(sup),
    .o_gate_n(gate_n), .o_ref_fixed(ref_fixed), .o_cs_charge(chg),
    .o_cs_fast_dis(fst), .o_cs_slow_dis(slw), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .o_irq(irq));

  buckg_plant buckg_plant_inst (
    .i_core_clk(clk), .i_gate_n(gate_n), .i_ref_fixed(ref_fixed), .i_charge(chg),
    .i_fast(fst), .i_slow(slw), .i_short(short), .i_light(light), .o_osc(osc),
    .o_cmp(cmp));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic test_done;
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int c;
    c = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    do begin
      @(posedge clk);
      c++;
    end while (wreq !== 1'b0 && c < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (c >= 50)
      n_errors++;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m);
    logic [31:0] q;
    exp_v.push_back(v & m);
    exp_m.push_back(m);
    bus(1'b0, a, 32'h0, 4'hf, q);
  endtask

  task automatic rdq(input logic [4:0] a, output logic [31:0] q);
    exp_v.push_back(32'h0);
    exp_m.push_back(32'h0);
    bus(1'b0, a, 32'h0, 4'hf, q);
  endtask

  task automatic wrc(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return ref_fixed;
      1: return slw;
      2: return fst;
      3: return chg;
      default: return irq;
    endcase
  endfunction

  task automatic wait_on(input int s, input logic v, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (pick(s) !== v && c < lim);
  endtask

  // read results are compared against the oldest note when accepted
  always @(posedge clk) begin
    if (rd && wreq === 1'b0 && exp_m.size() > 0) begin
      ev = exp_v.pop_front();
      em = exp_m.pop_front();
      if (em != 32'h0)
        check(rdata & em, ev);
    end
  end

  // ----------------------------------------------------------------------
  // continuous pin watch
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    lo_n <= osc ? 0 : lo_n + 1;
    if (!srst && lo_n == 4 && gate_n !== 1'b1)
      bad_dis++;
    if (!srst && slw === 1'b1 && gate_n !== 1'b1)
      bad_slow++;
    if (!srst && !cmp[2] && gate_n !== 1'b1)
      bad_hold++;
  end

  initial begin
    #300000;
    n_errors++;
    test_done;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(93));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({gate_n, ref_fixed, chg, fst, slw, irq}, 32'h20);
    rdc(`BUCKG_OFS_STATUS, 32'h1, 32'h3ff);
    rdc(`BUCKG_OFS_CTRL, 32'h1, 32'h1);
    rdc(`BUCKG_OFS_IRQ_MASK, 32'h0, 32'hf);
    wrc(5'h14, $urandom, 4'hf);
    rdc(5'h14, 32'h0, 32'hffffffff);
    wrc(`BUCKG_OFS_CTRL, 32'h0, 4'he);
    rdc(`BUCKG_OFS_CTRL, 32'h1, 32'h1);
    wait_on(0, 1'b1, 2000, n);
    check(n < 2000, 1);
    rdc(`BUCKG_OFS_STATUS, 32'h82, 32'h3bf);
    repeat (150) @(posedge clk);
    rdc(`BUCKG_OFS_STATUS, 32'h184, 32'h3bf);
    @(negedge clk);
    check(chg, 0);
    rdc(`BUCKG_OFS_IRQ_STAT, 32'h4, 32'h4);
    rdq(`BUCKG_OFS_PULSES, p1);
    repeat (100) @(posedge clk);
    rdq(`BUCKG_OFS_PULSES, p2);
    check(p2 != p1, 1);
    light <= 1'b1;
    // a latch set just before the override may stand to the end of that charge phase
    repeat (30) @(posedge clk);
    rdq(`BUCKG_OFS_PULSES, p1);
    wrc(`BUCKG_OFS_IRQ_STAT, 32'h8, 4'hf);
    k = 0;
    repeat (80) begin
      @(negedge clk);
      if (gate_n !== 1'b1)
        k++;
    end
    rdq(`BUCKG_OFS_PULSES, p2);
    check(k, 0);
    check(p2, p1);
    rdc(`BUCKG_OFS_IRQ_STAT, 32'h8, 32'h8);
    light <= 1'b0;
    short <= 1'b1;
    wait_on(2, 1'b1, 20, n);
    check(n < 20, 1);
    repeat ($urandom_range(60, 10)) @(posedge clk);
    short <= 1'b0;
    wait_on(2, 1'b0, 200, n);
    check(n < 200, 1);
    wait_on(3, 1'b1, 5, n);
    check(n < 5, 1);
    rdc(`BUCKG_OFS_STATUS, 32'h184, 32'h3bf);
    wrc(`BUCKG_OFS_IRQ_MASK, 32'h2, 4'hf);
    repeat (2) @(negedge clk);
    check(irq, 1);
    wrc(`BUCKG_OFS_IRQ_STAT, 32'h2, 4'hf);
    repeat (2) @(negedge clk);
    check(irq, 0);
    rdc(`BUCKG_OFS_IRQ_STAT, 32'h0, 32'h2);
    wrc(`BUCKG_OFS_IRQ_MASK, 32'h1, 4'hf);
    @(posedge clk);
    short <= 1'b1;
    wait_on(1, 1'b1, 300, n);
    check(n < 300, 1);
    rdc(`BUCKG_OFS_IRQ_STAT, 32'h1, 32'h1);
    check(irq, 1);
    wait_on(1, 1'b0, 2000, n);
    check(n > 800, 1);
    wait_on(1, 1'b1, 600, n);
    check(n < 600, 1);
    sup <= 1'b0;
    repeat (5) @(negedge clk);
    check({gate_n, slw}, 32'h2);
    rdc(`BUCKG_OFS_STATUS, 32'h1, 32'h3ff);
    short <= 1'b0;
    sup <= 1'b1;
    repeat (200) @(posedge clk);
    rdc(`BUCKG_OFS_STATUS, 32'h184, 32'h3bf);
    // run cleared by software behaves like supply loss
    wrc(`BUCKG_OFS_CTRL, 32'h0, 4'hf);
    repeat (3) @(posedge clk);
    rdc(`BUCKG_OFS_STATUS, 32'h1, 32'h3ff);
    rdc(`BUCKG_OFS_CTRL, 32'h0, 32'h1);
    wrc(`BUCKG_OFS_CTRL, 32'h1, 4'hf);
    repeat (100) @(posedge clk);
    rdc(`BUCKG_OFS_STATUS, 32'h184, 32'h3bf);
    check(bad_dis, 0);
    check(bad_slow, 0);
    check(bad_hold, 0);
    test_done;
  end
endmodule
